// file: mgmt_pkg.sv
package mgmt_pkg;

  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int INIT_TIME_MS = 2000;
  localparam int INIT_CYCLES = INIT_TIME_MS * CYC_PER_MS;
  localparam int WAKE_TIME_MS = 300;
  localparam int WAKE_CYCLES = WAKE_TIME_MS * CYC_PER_MS;
  localparam int TIMER_W = 27;

  // Flag layout
  localparam int LANES = 4;
  localparam int FLAG_W = 9;
  localparam int FLAG_LOS_LSB = 0;
  localparam int FLAG_TXF_LSB = 4;
  localparam int FLAG_READY = 8;

  // Register byte addresses
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_FLAGS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_CTRL = 8'h0C;

  // Status bit positions
  localparam int ST_DNR_BIT = 0;
  localparam int ST_INIT_BIT = 1;
  localparam int ST_LOWPWR_BIT = 2;
  localparam int ST_FUNC_BIT = 3;

  // Values after reset
  localparam logic [FLAG_W-1:0] MASK_RESET = 9'h000;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN = 2'b01,
    ST_LOW = 2'b10,
    ST_WAKE = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic los_pin_mode;
    logic disable_pin_mode;
    logic power_set;
    logic power_override;
  } ctrl_t;

endpackage : mgmt_pkg

// file: span_timer.sv
module span_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic [mgmt_pkg::TIMER_W-1:0] span_i,
  // Result
  output logic done_o
);

  logic [mgmt_pkg::TIMER_W-1:0] count_reg;
  logic [mgmt_pkg::TIMER_W-1:0] count_next;
  logic [mgmt_pkg::TIMER_W-1:0] last_count;

  // Span of zero behaves as one cycle
  assign last_count = (span_i == '0) ? '0 : span_i - 27'h0000001;
  assign done_o = (count_reg == last_count) && !clear_i;
  assign count_next = clear_i ? '0 : (done_o ? count_reg : count_reg + 27'h0000001);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

endmodule : span_timer

// file: module_mgmt.sv
// What this block does
// - Management init completes within 2000 ms of reset release.
// - Interrupt pin goes low within 200 ms of a triggering condition.
// - Interrupt released within 500 us after clear-on-read of its flag.
// - Receive loss sets its flag and pulls interrupt low within 100 ms.
// - Any flag condition sets its flag and asserts interrupt within 200 ms.
// - Setting a mask bit stops its interrupt within 100 ms.
// - Clearing a mask bit resumes its interrupt within 100 ms.
// - Within 2 s, clear data-not-ready and pull interrupt low.
// - Management bus answers within 2 s of power-on.
// - Fully functional within 2 s after module reset rises.
// - Fully functional within 2 s of power-on with low-power pin low.
// - Low-power/transmit-disable pin changes function within 100 ms.
// - Interrupt/receive-loss pin changes function within 100 ms.
// - Low-power pin high brings class 1 power within 100 ms.
// - Low-power pin low gives full function within 300 ms.
// - Power override or power set at 1 gives class 1 within 100 ms.
// - Both power bits cleared gives full function within 300 ms.
module module_mgmt #(
  parameter int INIT_CYCLES = mgmt_pkg::INIT_CYCLES,
  parameter int WAKE_CYCLES = mgmt_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host side-band pins
  input wire logic module_reset_n_i,
  input wire logic dual_mode_pin_i,
  output logic module_interrupt_n_o,
  // Line conditions
  input wire logic [mgmt_pkg::LANES-1:0] rx_los_i,
  input wire logic [mgmt_pkg::LANES-1:0] tx_fault_i,
  // Module power and lane control
  output logic transmit_disable_o,
  output logic low_power_o,
  output logic fully_functional_o,
  output logic management_init_state_o
);

  localparam int FW = mgmt_pkg::FLAG_W;

  mgmt_pkg::pwr_state_t state_reg;
  mgmt_pkg::pwr_state_t state_next;
  mgmt_pkg::ctrl_t ctrl_reg;
  logic [FW-1:0] flag_reg;
  logic [FW-1:0] flag_next;
  logic [FW-1:0] mask_reg;
  logic [FW-1:0] mask_next;
  logic [FW-1:0] ev;
  logic [FW-1:0] clr_vec;
  logic [31:0] rd_mux;
  logic [31:0] dat_reg;
  logic ack_reg;
  logic dnr_reg;
  logic int_n_reg;
  logic tx_off_reg;
  logic lowpwr_reg;
  logic func_reg;
  logic init_reg;
  logic soft_rst;
  logic bus_req;
  logic bus_fin;
  logic wr_en;
  logic flags_rd;
  logic hit_status;
  logic hit_flags;
  logic hit_mask;
  logic hit_ctrl;
  logic lp_pin_req;
  logic lp_target;
  logic int_active;
  logic timed_state;
  logic timer_clear;
  logic timer_done;
  logic init_done_ev;
  logic [mgmt_pkg::TIMER_W-1:0] span;

  // Host reset pin resets everything except the bus ack and read-data registers
  assign soft_rst = rst_i || !module_reset_n_i;

  // Bus decode
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_fin = wb_cyc_i && wb_stb_i && ack_reg;
  assign wr_en = bus_fin && wb_we_i;
  assign hit_status = (wb_adr_i == mgmt_pkg::ADR_STATUS);
  assign hit_flags = (wb_adr_i == mgmt_pkg::ADR_FLAGS);
  assign hit_mask = (wb_adr_i == mgmt_pkg::ADR_MASK);
  assign hit_ctrl = (wb_adr_i == mgmt_pkg::ADR_CTRL);
  assign flags_rd = bus_fin && !wb_we_i && hit_flags;

  // Unmapped addresses read zero
  assign rd_mux = hit_status ? {28'h0000000, func_reg, lowpwr_reg, init_reg, dnr_reg} :
                  hit_flags ? {23'h000000, flag_reg} :
                  hit_mask ? {23'h000000, mask_reg} :
                  hit_ctrl ? {28'h0000000, ctrl_reg} : 32'h00000000;

  // Only the bits actually returned are cleared, so late events survive
  assign clr_vec = flags_rd ? dat_reg[FW-1:0] : '0;

  assign mask_next = {wr_en && hit_mask && wb_sel_i[1] ? wb_dat_i[8] : mask_reg[8],
                      wr_en && hit_mask && wb_sel_i[0] ? wb_dat_i[7:0] : mask_reg[7:0]};

  // Flag sources
  assign init_done_ev = (state_reg == mgmt_pkg::ST_INIT) && (state_next != mgmt_pkg::ST_INIT);
  assign ev = {init_done_ev, tx_fault_i, rx_los_i};

  genvar gi;
  generate
    for (gi = 0; gi < FW; gi++)
    begin : g_flag
      // Set wins over a read clear in the same cycle
      assign flag_next[gi] = (flag_reg[gi] && !clr_vec[gi]) || ev[gi];
    end
  endgenerate

  assign int_active = |(flag_reg & ~mask_reg);

  // Dual-function pin decode
  assign lp_pin_req = !ctrl_reg.disable_pin_mode && dual_mode_pin_i;
  assign lp_target = lp_pin_req || ctrl_reg.power_override || ctrl_reg.power_set;

  // Power sequencing
  assign timed_state = (state_reg == mgmt_pkg::ST_INIT) || (state_reg == mgmt_pkg::ST_WAKE);
  assign timer_clear = !module_reset_n_i || !timed_state;
  assign span = (state_reg == mgmt_pkg::ST_INIT) ? INIT_CYCLES[mgmt_pkg::TIMER_W-1:0] :
                WAKE_CYCLES[mgmt_pkg::TIMER_W-1:0];

  span_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(timer_clear),
    .span_i(span),
    .done_o(timer_done)
  );

  always_comb
  begin
    state_next = state_reg;
    if (!module_reset_n_i)
      state_next = mgmt_pkg::ST_INIT;
    else
    begin
      case (state_reg)
        mgmt_pkg::ST_INIT:
          if (timer_done)
            state_next = lp_target ? mgmt_pkg::ST_LOW : mgmt_pkg::ST_RUN;
        mgmt_pkg::ST_RUN:
          if (lp_target)
            state_next = mgmt_pkg::ST_LOW;
        mgmt_pkg::ST_LOW:
          if (!lp_target)
            state_next = mgmt_pkg::ST_WAKE;
        mgmt_pkg::ST_WAKE:
          if (lp_target)
            state_next = mgmt_pkg::ST_LOW;
          else if (timer_done)
            state_next = mgmt_pkg::ST_RUN;
        default:
          state_next = mgmt_pkg::ST_INIT;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= bus_req;
      dat_reg <= bus_req ? rd_mux : dat_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (soft_rst)
    begin
      state_reg <= mgmt_pkg::ST_INIT;
      flag_reg <= '0;
      mask_reg <= mgmt_pkg::MASK_RESET;
      ctrl_reg <= mgmt_pkg::CTRL_RESET;
      dnr_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      flag_reg <= flag_next;
      mask_reg <= mask_next;
      ctrl_reg <= (wr_en && hit_ctrl && wb_sel_i[0]) ? mgmt_pkg::ctrl_t'(wb_dat_i[3:0]) : ctrl_reg;
      dnr_reg <= dnr_reg && !init_done_ev;
    end
  end

  // Pin and status outputs, all registered
  always_ff @(posedge clk_i)
  begin
    if (soft_rst)
    begin
      int_n_reg <= 1'b1;
      tx_off_reg <= 1'b0;
      lowpwr_reg <= 1'b0;
      func_reg <= 1'b0;
      init_reg <= 1'b1;
    end
    else
    begin
      int_n_reg <= ctrl_reg.los_pin_mode ? !(|rx_los_i) : !int_active;
      tx_off_reg <= ctrl_reg.disable_pin_mode && dual_mode_pin_i;
      lowpwr_reg <= (state_next == mgmt_pkg::ST_LOW);
      func_reg <= (state_next == mgmt_pkg::ST_RUN);
      init_reg <= (state_next == mgmt_pkg::ST_INIT);
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign module_interrupt_n_o = int_n_reg;
  assign transmit_disable_o = tx_off_reg;
  assign low_power_o = lowpwr_reg;
  assign fully_functional_o = func_reg;
  assign management_init_state_o = init_reg;

  // Helper ages for the long deadlines
  int init_age;
  int wake_age;
  always_ff @(posedge clk_i)
  begin
    if (soft_rst || state_reg != mgmt_pkg::ST_INIT)
      init_age <= 0;
    else
      init_age <= init_age + 1;
    if (soft_rst || state_reg != mgmt_pkg::ST_WAKE)
      wake_age <= 0;
    else
      wake_age <= wake_age + 1;
  end

  AST_INIT_BOUND: assert property (@(posedge clk_i) disable iff (soft_rst)
    init_age < INIT_CYCLES + 1)
    else $error("init state overran its span");

  AST_RESET_INIT: assert property (@(posedge clk_i) disable iff (rst_i)
    !module_reset_n_i |=> management_init_state_o && !fully_functional_o && dnr_reg)
    else $error("module reset did not restart init");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (soft_rst)
    (ev != '0) |=> ((flag_reg & $past(ev)) == $past(ev)))
    else $error("event did not set its flag");

  AST_LATCH: assert property (@(posedge clk_i) disable iff (soft_rst)
    ##1 ((flag_reg & $past(flag_reg & ~clr_vec)) == $past(flag_reg & ~clr_vec)))
    else $error("flag dropped without a read");

  AST_INT_ON: assert property (@(posedge clk_i) disable iff (soft_rst)
    (int_active && !ctrl_reg.los_pin_mode) |=> !module_interrupt_n_o)
    else $error("interrupt not asserted for unmasked flag");

  AST_INT_OFF: assert property (@(posedge clk_i) disable iff (soft_rst)
    (flags_rd && !ctrl_reg.los_pin_mode && mask_reg == '0 && ev == '0) |=> ##1
    (module_interrupt_n_o == !(|$past(flag_reg))))
    else $error("interrupt not released after flag read");

  AST_MASK_ON: assert property (@(posedge clk_i) disable iff (soft_rst)
    (mask_reg == {FW{1'b1}} && !ctrl_reg.los_pin_mode) |=> module_interrupt_n_o)
    else $error("masked flags still drive the interrupt");

  AST_MASK_OFF: assert property (@(posedge clk_i) disable iff (soft_rst)
    ($fell(mask_reg[0]) && flag_reg[0] && !ctrl_reg.los_pin_mode) |=> !module_interrupt_n_o)
    else $error("unmask did not resume interrupt");

  AST_READY: assert property (@(posedge clk_i) disable iff (soft_rst)
    $fell(management_init_state_o) |-> !dnr_reg && flag_reg[mgmt_pkg::FLAG_READY])
    else $error("init end without ready flag");

  AST_LOWPWR: assert property (@(posedge clk_i) disable iff (soft_rst)
    (lp_target && state_reg != mgmt_pkg::ST_INIT) |=> low_power_o)
    else $error("low power not reached");

  AST_WAKE_BOUND: assert property (@(posedge clk_i) disable iff (soft_rst)
    wake_age < WAKE_CYCLES + 1)
    else $error("wake overran its span");

  AST_PIN_MODE: assert property (@(posedge clk_i) disable iff (soft_rst)
    ctrl_reg.los_pin_mode |=> (module_interrupt_n_o == !(|$past(rx_los_i))))
    else $error("receive-loss pin mode wrong");

  AST_TRANSMIT_DISABLE: assert property (@(posedge clk_i) disable iff (soft_rst)
    ctrl_reg.disable_pin_mode |=> (transmit_disable_o == $past(dual_mode_pin_i)))
    else $error("transmit disable not following pin");

  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus not answered in one cycle");

endmodule : module_mgmt

// file: host_sideband_model.sv
module host_sideband_model #(
  parameter int RESET_LOW_CYCLES = 500
) (
  // Clock
  input wire logic clk_i,
  // Side-band pins
  output logic module_reset_n_o,
  output logic dual_mode_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    module_reset_n_o = 1'b1;
    dual_mode_pin_o = 1'b0;
  end

  // 10 us at 50 MHz; shorter pulses need not reset
  task automatic reset_pulse();
    module_reset_n_o <= 1'b0;
    repeat (RESET_LOW_CYCLES) @(posedge clk_i);
    module_reset_n_o <= 1'b1;
  endtask : reset_pulse

  task automatic set_lp(input logic v);
    dual_mode_pin_o <= v;
  endtask : set_lp
endmodule : host_sideband_model

// file: pluggable_module_mgmt_timing_tb.sv
module pluggable_module_mgmt_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 20;
  localparam int WAKE = 10;
  logic clk_i, rst_i, cyc, stb, we, ack, rst_n, lp, int_n, tx_off, lowp, func, init;
  logic [7:0] adr;
  logic [3:0] sel, rx_los, tx_fault;
  logic [31:0] wdat, dat_o, rd, v;
  int err_total, num_checks, cycles, seed, exp_flags;
  int exp_q[$];

  module_mgmt #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) u_module_mgmt (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .module_reset_n_i(rst_n), .dual_mode_pin_i(lp), .module_interrupt_n_o(int_n),
    .rx_los_i(rx_los), .tx_fault_i(tx_fault), .transmit_disable_o(tx_off),
    .low_power_o(lowp), .fully_functional_o(func), .management_init_state_o(init));

  host_sideband_model u_host_sideband_model (
    .clk_i(clk_i), .module_reset_n_o(rst_n), .dual_mode_pin_o(lp));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Holds the request until ack is sampled high at a rising edge
  // No wait limit of its own: a missing ack ends in the bench timeout
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    chk(32'(ack), 32'h0);
  endtask : bus

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : settle

  task automatic wait_func(input int limit);
    int n;
    n = 0;
    while (func !== 1'b1 && n < limit)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_func

  // Ceiling well above the fewer than a thousand cycles the sequence needs
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    seed = 80;
    rst_i = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    rx_los = 4'h0;
    tx_fault = 4'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(2);
    chk(32'(init), 32'h1);
    wait_func(INIT + 3);
    chk(32'(func), 32'h1);
    settle(2);
    chk(32'(int_n), 32'h0);
    bus(1'b0, mgmt_pkg::ADR_STATUS, 32'h0);
    chk(rd, 32'h8);
    bus(1'b0, mgmt_pkg::ADR_FLAGS, 32'h0);
    chk(rd, 32'h100);
    settle(1);
    chk(32'(int_n), 32'h1);
    // Two pulses per read; both must stay latched until read
    for (int i = 0; i < 8; i++)
    begin
      exp_flags = 0;
      for (int p = 0; p < 2; p++)
      begin
        v = $random(seed);
        if (v[7:0] == 8'h00)
          v[0] = 1'b1;
        rx_los <= v[3:0];
        tx_fault <= v[7:4];
        @(posedge clk_i);
        rx_los <= 4'h0;
        tx_fault <= 4'h0;
        exp_flags = exp_flags | int'(v[7:0]);
        @(posedge clk_i);
      end
      exp_q.push_back(exp_flags);
      settle(1);
      chk(32'(int_n), 32'h0);
      bus(1'b0, mgmt_pkg::ADR_FLAGS, 32'h0);
      chk(rd, 32'(exp_q.pop_front()));
      settle(1);
      chk(32'(int_n), 32'h1);
    end
    rx_los <= 4'h1;
    bus(1'b1, mgmt_pkg::ADR_MASK, 32'h1FF);
    settle(2);
    chk(32'(int_n), 32'h1);
    bus(1'b1, mgmt_pkg::ADR_MASK, 32'h0);
    settle(2);
    chk(32'(int_n), 32'h0);
    rx_los <= 4'h0;
    bus(1'b0, mgmt_pkg::ADR_FLAGS, 32'h0);
    chk(rd, 32'h1);
    settle(1);
    chk(32'(int_n), 32'h1);
    bus(1'b1, mgmt_pkg::ADR_CTRL, 32'h8);
    rx_los <= 4'h4;
    settle(2);
    chk(32'(int_n), 32'h0);
    rx_los <= 4'h0;
    settle(2);
    chk(32'(int_n), 32'h1);
    bus(1'b1, mgmt_pkg::ADR_CTRL, 32'h4);
    u_host_sideband_model.set_lp(1'b1);
    settle(2);
    chk(32'({tx_off, lowp}), 32'h2);
    bus(1'b1, mgmt_pkg::ADR_CTRL, 32'h0);
    settle(2);
    chk(32'(lowp), 32'h1);
    bus(1'b0, mgmt_pkg::ADR_FLAGS, 32'h0);
    chk(rd, 32'h4);
    u_host_sideband_model.set_lp(1'b0);
    wait_func(WAKE + 3);
    chk(32'({func, lowp}), 32'h2);
    for (int b = 0; b < 2; b++)
    begin
      bus(1'b1, mgmt_pkg::ADR_CTRL, 32'(1 << b));
      settle(2);
      chk(32'(lowp), 32'h1);
      bus(1'b1, mgmt_pkg::ADR_CTRL, 32'h0);
      wait_func(WAKE + 3);
      chk(32'({func, lowp}), 32'h2);
    end
    u_host_sideband_model.reset_pulse();
    settle(1);
    chk(32'(init), 32'h1);
    wait_func(INIT + 3);
    chk(32'(func), 32'h1);
    bus(1'b1, mgmt_pkg::ADR_STATUS, 32'hF);
    bus(1'b0, mgmt_pkg::ADR_STATUS, 32'h0);
    chk(rd, 32'h8);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule : pluggable_module_mgmt_timing_tb
